// ### src/hss_pkg.sv
// shared constants, types and tables of the hub stage sequencer
package hss_pkg;

    // timing figures in their own units
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned US_PER_S         = 1_000_000;
    localparam int unsigned US_PER_MS        = 1_000;
    localparam int unsigned T_INIT_TYP_US    = 3_000;
    localparam int unsigned T_INIT_MAX_US    = 4_000;
    localparam int unsigned T_CFG_MIN_US     = 94_000;
    localparam int unsigned T_CFG_TYP_US     = 95_000;
    localparam int unsigned T_CFG_MAX_US     = 96_000;
    localparam int unsigned T_CONNECT_MAX_US = 10;
    localparam int unsigned T_RESET_MIN_US   = 100;

    // derived cycle counts at clk_sys: least times round up, longest round down
    localparam int unsigned RESET_MIN_CYC   =
        (T_RESET_MIN_US * (CLK_HZ / 1_000) + 999) / 1_000;
    localparam int unsigned CONNECT_MAX_CYC = T_CONNECT_MAX_US * (CLK_HZ / US_PER_S);
    localparam int unsigned INIT_HOLD_CYC   = T_INIT_MAX_US * (CLK_HZ / US_PER_S);

    // device register offsets
    localparam logic [7:0] REG_ILOCK      = 8'hE7;
    localparam logic [7:0] REG_INT_STATUS = 8'hE8;
    localparam logic [7:0] REG_INT_MASK   = 8'hE9;
    localparam logic [7:0] REG_CFGP       = 8'hEE;

    // device field positions
    localparam int unsigned ILOCK_CONFIG_N_BIT  = 0;
    localparam int unsigned ILOCK_CONNECT_N_BIT = 1;
    localparam int unsigned CFGP_SUSP_LEVEL_BIT = 0;

    // device reset values
    localparam logic [7:0] ILOCK_RST  = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] CFGP_RST   = 8'h00;

    // host controller register offsets and fields
    localparam logic [3:0] HREG_CTRL   = 4'h0;
    localparam logic [3:0] HREG_SP_CMD = 4'h4;
    localparam logic [3:0] HREG_STATUS = 4'h8;
    localparam int unsigned CTRL_RUN_BIT       = 0;
    localparam int unsigned CTRL_SECONDARY_BIT = 1;
    localparam int unsigned CTRL_CONNECT_BIT   = 2;
    localparam int unsigned CTRL_REF_SEL_LSB   = 3;
    localparam int unsigned CMD_ADDR_LSB       = 8;
    localparam int unsigned CMD_READ_BIT       = 16;
    localparam int unsigned STAT_ANSWERED_BIT  = 8;
    localparam int unsigned STAT_INT_LOW_BIT   = 9;
    localparam int unsigned STAT_RELEASED_BIT  = 10;
    localparam logic [4:0]  CTRL_RST           = 5'h00;

    typedef enum logic [2:0] {
        STG_STANDBY = 3'h0,
        STG_INIT    = 3'h1,
        STG_WAITREF = 3'h3,
        STG_CONFIG  = 3'h2,
        STG_CONNECT = 3'h6,
        STG_COMM    = 3'h7
    } hss_stage_e;

    // reference frequency in kHz for a strap pair and table choice
    function automatic logic [15:0] hss_freq_khz(input logic secondary, input logic [1:0] sel);
        logic [15:0] f;
        f = 16'h0000;
        if (!secondary) begin
            case (sel)
                2'b00:   f = 16'd38400;
                2'b01:   f = 16'd26000;
                2'b10:   f = 16'd19200;
                default: f = 16'd12000;
            endcase
        end else begin
            case (sel)
                2'b00:   f = 16'd24000;
                2'b01:   f = 16'd27000;
                2'b10:   f = 16'd25000;
                default: f = 16'd50000;
            endcase
        end
        return f;
    endfunction : hss_freq_khz

endpackage : hss_pkg

// ### src/hss_link_if.sv
// pins between the hub sequencer and the host system processor
interface hss_link_if;
    logic       reset_n;
    logic [1:0] ref_sel;
    logic       connect;
    logic       dev_int_o;
    logic       dev_int_oe;
    logic       host_int_o;
    logic       host_int_oe;
    logic       int_line;
    logic [7:0] sp_addr;
    logic [7:0] sp_wdata;
    logic       sp_wr;
    logic       sp_rd;
    logic [7:0] sp_rdata;
    logic       sp_rvalid;

    // open drain with pull-up: low whenever either end drives a zero
    assign int_line = !((dev_int_oe && !dev_int_o) || (host_int_oe && !host_int_o));

    modport device (
        input  reset_n, ref_sel, connect, int_line, sp_addr, sp_wdata, sp_wr, sp_rd,
        output dev_int_o, dev_int_oe, sp_rdata, sp_rvalid
    );

    modport host (
        input  int_line, sp_rdata, sp_rvalid,
        output reset_n, ref_sel, connect, host_int_o, host_int_oe,
        output sp_addr, sp_wdata, sp_wr, sp_rd
    );
endinterface : hss_link_if

// ### src/hss_device.sv
// hub stage sequencer, device end: stages, strap latch, interrupt pin, registers
module hss_device #(
    parameter logic [7:0]  ROM_ILOCK    = hss_pkg::ILOCK_RST,
    parameter logic [7:0]  ROM_MASK     = hss_pkg::MASK_RST,
    parameter logic [7:0]  ROM_CFGP     = hss_pkg::CFGP_RST,
    parameter int unsigned INIT_TIME_US = hss_pkg::T_INIT_TYP_US,
    parameter int unsigned CFG_TIME_US  = hss_pkg::T_CFG_TYP_US,
    parameter int unsigned EVT_W        = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    hss_link_if.device            link,
    input  wire logic [EVT_W-1:0] evt_cond,
    input  wire logic             hub_suspended,
    input  wire logic             ref_clk_ok,
    input  wire logic             pll_locked,
    output hss_pkg::hss_stage_e   stage,
    output logic                  ports_enabled,
    output logic                  pll_enable,
    output logic [15:0]           freq_khz,
    output logic                  secondary_table,
    output logic [1:0]            ref_sel_latched
);

    initial begin
        if (EVT_W < 1 || EVT_W > 8) begin
            $error("hss_device: EVT_W must be 1 to 8");
        end
        if (INIT_TIME_US < 1 || INIT_TIME_US > hss_pkg::T_INIT_MAX_US) begin
            $error("hss_device: INIT_TIME_US out of range");
        end
        if (CFG_TIME_US < 1) begin
            $error("hss_device: CFG_TIME_US must be positive");
        end
        // connect latency is the pin filter plus one stage step
        if (hss_pkg::CONNECT_MAX_CYC < 5) begin
            $error("hss_device: connect latency exceeds limit");
        end
    end

    typedef struct packed {
        logic [2:0]       rst_s;
        logic             rst_f;
        logic [2:0][1:0]  sel_s;
        logic [1:0]       sel_f;
        logic [2:0]       con_s;
        logic             con_f;
        logic [2:0]       int_s;
        logic             int_f;
        hss_pkg::hss_stage_e stage;
        logic [31:0]      timer;
        logic [1:0]       ref_sel_l;
        logic             secondary;
        logic [15:0]      freq_khz;
        logic [7:0]       ilock;
        logic [7:0]       status;
        logic [7:0]       mask;
        logic [7:0]       cfgp;
        logic             cfg_written;
        logic [EVT_W-1:0] evt_prev;
        logic             int_drive;
        logic             rvalid;
        logic [7:0]       rdata;
    } hss_dev_s;

    hss_dev_s    q;
    hss_dev_s    d;
    logic [47:0] init_prod;
    logic [47:0] cfg_prod;
    logic [31:0] init_tc;
    logic [31:0] cfg_tc;

    assign init_prod = 48'(q.freq_khz) * 48'(INIT_TIME_US);
    assign cfg_prod  = 48'(q.freq_khz) * 48'(CFG_TIME_US);
    assign init_tc   = 32'(init_prod / 48'(hss_pkg::US_PER_MS));
    assign cfg_tc    = 32'(cfg_prod / 48'(hss_pkg::US_PER_MS));

    always_comb begin
        logic       sp_ok;
        logic       hub_up;
        logic       clk_ok;
        logic [7:0] clr;
        logic [7:0] rise;
        sp_ok  = 1'b0;
        hub_up = 1'b0;
        clk_ok = 1'b0;
        clr    = 8'h00;
        rise   = 8'h00;
        d      = q;

        // three-stage pin filters: a change counts once stages two and three agree
        d.rst_s = {q.rst_s[1:0], link.reset_n};
        d.rst_f = (q.rst_s[1] == q.rst_s[2]) ? q.rst_s[2] : q.rst_f;
        d.sel_s = {q.sel_s[1:0], link.ref_sel};
        d.sel_f = (q.sel_s[1] == q.sel_s[2]) ? q.sel_s[2] : q.sel_f;
        d.con_s = {q.con_s[1:0], link.connect};
        d.con_f = (q.con_s[1] == q.con_s[2]) ? q.con_s[2] : q.con_f;
        d.int_s = {q.int_s[1:0], link.int_line};
        d.int_f = (q.int_s[1] == q.int_s[2]) ? q.int_s[2] : q.int_f;

        d.evt_prev = evt_cond;
        d.rvalid   = 1'b0;
        d.rdata    = 8'h00;
        clk_ok     = ref_clk_ok && pll_locked;
        hub_up     = (q.stage == hss_pkg::STG_CONFIG) || (q.stage == hss_pkg::STG_CONNECT)
                     || (q.stage == hss_pkg::STG_COMM);
        // port answers in config and connect only
        sp_ok      = (q.stage == hss_pkg::STG_CONFIG) || (q.stage == hss_pkg::STG_CONNECT);

        if (sp_ok && link.sp_rd) begin
            d.rvalid = 1'b1;
            if (link.sp_addr == hss_pkg::REG_ILOCK) begin
                d.rdata = q.ilock;
            end else if (link.sp_addr == hss_pkg::REG_INT_STATUS) begin
                d.rdata = q.status;
            end else if (link.sp_addr == hss_pkg::REG_INT_MASK) begin
                d.rdata = q.mask;
            end else if (link.sp_addr == hss_pkg::REG_CFGP) begin
                d.rdata = q.cfgp;
            end else begin
                d.rdata = 8'h00;
            end
        end
        if (sp_ok && link.sp_wr) begin
            if (link.sp_addr == hss_pkg::REG_ILOCK) begin
                d.ilock       = link.sp_wdata;
                d.cfg_written = 1'b1;
            end else if (link.sp_addr == hss_pkg::REG_INT_STATUS) begin
                clr = link.sp_wdata;
            end else if (link.sp_addr == hss_pkg::REG_INT_MASK) begin
                d.mask = link.sp_wdata;
            end else if (link.sp_addr == hss_pkg::REG_CFGP) begin
                d.cfgp = link.sp_wdata;
            end
        end

        // only a rising condition sets a bit
        rise = 8'(evt_cond & ~q.evt_prev);
        // sticky, write one clears, set wins
        if (hub_up) begin
            d.status = (q.status & ~clr) | rise;
        end

        case (q.stage)
            hss_pkg::STG_STANDBY: begin
                d.stage = hss_pkg::STG_INIT;
                d.timer = '0;
            end
            hss_pkg::STG_INIT: begin
                d.timer       = q.timer + 32'h0000_0001;
                d.ref_sel_l   = q.sel_f;
                d.secondary   = !q.int_f;
                d.freq_khz    = hss_pkg::hss_freq_khz(!q.int_f, q.sel_f);
                d.ilock       = ROM_ILOCK;
                d.mask        = ROM_MASK;
                d.cfgp        = ROM_CFGP;
                d.status      = hss_pkg::STATUS_RST;
                d.cfg_written = 1'b0;
                // first cycle skipped while the frequency settles
                // leave after init time
                if (q.timer != '0 && q.timer >= init_tc) begin
                    d.timer = '0;
                    d.stage = clk_ok ? hss_pkg::STG_CONFIG : hss_pkg::STG_WAITREF;
                end
            end
            hss_pkg::STG_WAITREF: begin
                if (clk_ok) begin
                    d.stage = hss_pkg::STG_CONFIG;
                    d.timer = '0;
                end
            end
            hss_pkg::STG_CONFIG: begin
                // saturates so an indefinite stay cannot wrap into a timeout
                if (q.timer != '1) begin
                    d.timer = q.timer + 32'h0000_0001;
                end
                if (!q.ilock[hss_pkg::ILOCK_CONFIG_N_BIT]
                    && (q.cfg_written || q.timer >= cfg_tc)) begin
                    d.stage = hss_pkg::STG_CONNECT;
                    d.timer = '0;
                end
            end
            hss_pkg::STG_CONNECT: begin
                if (q.con_f || q.ilock[hss_pkg::ILOCK_CONNECT_N_BIT]) begin
                    d.stage = hss_pkg::STG_COMM;
                end
            end
            hss_pkg::STG_COMM: begin
                d.stage = hss_pkg::STG_COMM;
            end
            default: begin
                d.stage = hss_pkg::STG_STANDBY;
            end
        endcase

        // mask gates status onto the pin, unless CFGP bit 0 selects the suspend level shown in communication
        d.int_drive = 1'b0;
        if (hub_up) begin
            if (q.cfgp[hss_pkg::CFGP_SUSP_LEVEL_BIT]) begin
                d.int_drive = (q.stage == hss_pkg::STG_COMM) && hub_suspended;
            end else begin
                d.int_drive = |(q.status & q.mask);
            end
        end

        if (!q.rst_f) begin
            d.stage       = hss_pkg::STG_STANDBY;
            d.timer       = '0;
            d.ilock       = hss_pkg::ILOCK_RST;
            d.status      = hss_pkg::STATUS_RST;
            d.mask        = hss_pkg::MASK_RST;
            d.cfgp        = hss_pkg::CFGP_RST;
            d.cfg_written = 1'b0;
            d.ref_sel_l   = 2'h0;
            d.secondary   = 1'b0;
            d.freq_khz    = 16'h0000;
            d.int_drive   = 1'b0;
            d.rvalid      = 1'b0;
            d.rdata       = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // drive zero with enable, else float
    assign link.dev_int_o  = 1'b0;
    assign link.dev_int_oe = q.int_drive;
    assign link.sp_rdata   = q.rdata;
    assign link.sp_rvalid  = q.rvalid;

    assign stage           = q.stage;
    // ports on in communication only, PLL halted in standby only
    assign ports_enabled   = (q.stage == hss_pkg::STG_COMM);
    assign pll_enable      = (q.stage != hss_pkg::STG_STANDBY);
    assign freq_khz        = q.freq_khz;
    assign secondary_table = q.secondary;
    assign ref_sel_latched = q.ref_sel_l;

endmodule : hss_device

// ### src/hss_host.sv
// hub stage sequencer, host end: reset, straps, connect pin and serial commands
module hss_host #(
    parameter int unsigned INIT_HOLD_CYC = hss_pkg::INIT_HOLD_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    hss_link_if.host         link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata
);

    initial begin
        if (INIT_HOLD_CYC < 1) begin
            $error("hss_host: INIT_HOLD_CYC must be positive");
        end
    end

    typedef struct packed {
        logic [4:0]  ctrl;
        logic [11:0] rst_cnt;
        logic        released;
        logic [31:0] hold_cnt;
        logic        int_pull;
        logic [7:0]  sp_addr;
        logic [7:0]  sp_wdata;
        logic        sp_wr;
        logic        sp_rd;
        logic        pending;
        logic        answered;
        logic [7:0]  sp_rdata;
        logic [2:0]  int_s;
        logic        int_f;
        logic [31:0] rdata;
    } hss_host_s;

    hss_host_s q;
    hss_host_s d;

    always_comb begin
        d          = q;
        d.int_s    = {q.int_s[1:0], link.int_line};
        d.int_f    = (q.int_s[1] == q.int_s[2]) ? q.int_s[2] : q.int_f;
        d.sp_wr    = 1'b0;
        d.sp_rd    = 1'b0;
        d.pending  = q.sp_rd;
        d.rdata    = 32'h0000_0000;

        if (!q.ctrl[hss_pkg::CTRL_RUN_BIT]) begin
            d.rst_cnt  = '0;
            d.released = 1'b0;
            d.hold_cnt = '0;
        end else if (!q.released) begin
            if (q.rst_cnt == 12'(hss_pkg::RESET_MIN_CYC - 1)) begin
                d.released = 1'b1;
            end else begin
                d.rst_cnt = q.rst_cnt + 12'h001;
            end
        end else if (q.hold_cnt != INIT_HOLD_CYC) begin
            d.hold_cnt = q.hold_cnt + 32'h0000_0001;
        end
        // pull the line through init when the secondary table is chosen, then release
        d.int_pull = q.ctrl[hss_pkg::CTRL_SECONDARY_BIT] && q.ctrl[hss_pkg::CTRL_RUN_BIT]
                     && (q.hold_cnt != INIT_HOLD_CYC);

        if (q.pending) begin
            d.answered = link.sp_rvalid;
            d.sp_rdata = link.sp_rdata;
        end

        if (wr) begin
            if (addr == hss_pkg::HREG_CTRL) begin
                d.ctrl = wdata[4:0];
            end else if (addr == hss_pkg::HREG_SP_CMD) begin
                d.sp_wdata = wdata[7:0];
                d.sp_addr  = wdata[hss_pkg::CMD_ADDR_LSB +: 8];
                d.sp_rd    = wdata[hss_pkg::CMD_READ_BIT];
                d.sp_wr    = !wdata[hss_pkg::CMD_READ_BIT];
                d.answered = 1'b0;
            end
        end
        if (rd) begin
            if (addr == hss_pkg::HREG_CTRL) begin
                d.rdata = {27'h000_0000, q.ctrl};
            end else if (addr == hss_pkg::HREG_STATUS) begin
                d.rdata = {21'h00_0000, q.released, !q.int_f, q.answered, q.sp_rdata};
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.reset_n     = q.released;
    assign link.ref_sel     = q.ctrl[hss_pkg::CTRL_REF_SEL_LSB +: 2];
    assign link.connect     = q.ctrl[hss_pkg::CTRL_CONNECT_BIT];
    assign link.host_int_o  = 1'b0;
    assign link.host_int_oe = q.int_pull;
    assign link.sp_addr     = q.sp_addr;
    assign link.sp_wdata    = q.sp_wdata;
    assign link.sp_wr       = q.sp_wr;
    assign link.sp_rd       = q.sp_rd;
    assign rdata            = q.rdata;

endmodule : hss_host

// ### testbench/hss_sva.sv
// link checks for the hub stage sequencer
module hss_sva (
    input wire logic           clk_sys,
    input wire logic           arst_n,
    input wire logic           reset_n,
    input wire logic           dev_int_o,
    input wire logic           dev_int_oe,
    input wire logic           sp_rd,
    input wire logic           sp_rvalid,
    input hss_pkg::hss_stage_e stage
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_pin_open_drain: assert property (dev_int_oe |-> !dev_int_o)
        else $error("line driven high");
    // three filter flops, one flag flop, then the stage flop
    a_standby_force: assert property (!reset_n [*6] |-> stage == hss_pkg::STG_STANDBY)
        else $error("no standby under reset");
    a_init_first: assert property (stage == hss_pkg::STG_STANDBY
        |=> stage inside {hss_pkg::STG_STANDBY, hss_pkg::STG_INIT})
        else $error("standby left to a wrong stage");
    a_init_exit: assert property (stage == hss_pkg::STG_INIT |=> stage inside
        {hss_pkg::STG_STANDBY, hss_pkg::STG_INIT, hss_pkg::STG_WAITREF, hss_pkg::STG_CONFIG})
        else $error("init left to a wrong stage");
    a_init_min: assert property (stage == hss_pkg::STG_INIT && $changed(stage)
        |-> stage == hss_pkg::STG_INIT [*8])
        else $error("init too short");
    a_comm_hold: assert property (stage == hss_pkg::STG_COMM && reset_n
        |=> stage == hss_pkg::STG_COMM)
        else $error("communication left without reset");
    a_port_quiet: assert property (sp_rd && !(stage inside
        {hss_pkg::STG_CONFIG, hss_pkg::STG_CONNECT}) |=> !sp_rvalid)
        else $error("serial answer outside config");
    a_port_answer: assert property (sp_rd && stage inside
        {hss_pkg::STG_CONFIG, hss_pkg::STG_CONNECT} |=> sp_rvalid)
        else $error("serial read not answered");
    a_answer_cause: assert property (sp_rvalid |-> $past(sp_rd))
        else $error("answer without read");
    a_int_quiet: assert property ($stable(stage) && stage inside
        {hss_pkg::STG_STANDBY, hss_pkg::STG_INIT, hss_pkg::STG_WAITREF} |-> !dev_int_oe)
        else $error("line pulled before config");
endmodule : hss_sva

// ### testbench/hub_stage_sequencer_tb.sv
// self-checking bench joining the host and device ends of the sequencer
module hub_stage_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT_US  = 1;
    localparam int CFG_US   = 2;
    localparam int INIT_CYC = 38400 * INIT_US / 1000;
    localparam int CFG_CYC  = 38400 * CFG_US / 1000;
    // nonzero so a missed load from the default image shows
    localparam logic [7:0] ROM_MASK_TB = 8'h80;
    // kHz: primary 00..11, then secondary 00..11
    localparam logic [15:0] FTAB [8] = '{16'h9600, 16'h6590, 16'h4B00, 16'h2EE0,
                                         16'h5DC0, 16'h6978, 16'h61A8, 16'hC350};
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        h_wr    = 1'b0;
    logic        h_rd    = 1'b0;
    logic [7:0]  evt     = 8'h00;
    logic        susp    = 1'b0;
    logic        clk_ok  = 1'b1;
    logic        lock    = 1'b1;
    logic [31:0] rdata, d;
    logic        ports_en, pll_en, sec_tbl;
    logic [15:0] freq;
    logic [1:0]  rsel;
    hss_pkg::hss_stage_e stage;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          c;

    hss_link_if link ();
    hss_device #(.INIT_TIME_US(INIT_US), .CFG_TIME_US(CFG_US),
        .ROM_MASK(ROM_MASK_TB)) hss_device_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .link(link), .evt_cond(evt),
        .hub_suspended(susp), .ref_clk_ok(clk_ok), .pll_locked(lock), .stage(stage),
        .ports_enabled(ports_en), .pll_enable(pll_en), .freq_khz(freq),
        .secondary_table(sec_tbl), .ref_sel_latched(rsel));
    hss_host #(.INIT_HOLD_CYC(200)) hss_host_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .link(link), .addr(addr), .wdata(wdata), .wr(h_wr), .rd(h_rd), .rdata(rdata));
    hss_sva hss_sva_inst (.clk_sys(clk_sys), .arst_n(arst_n), .reset_n(link.reset_n),
        .dev_int_o(link.dev_int_o), .dev_int_oe(link.dev_int_oe), .sp_rd(link.sp_rd),
        .sp_rvalid(link.sp_rvalid), .stage(stage));

    always #25 clk_sys = ~clk_sys;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // step past the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic bw(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        h_wr  <= 1'b1;
        @(posedge clk_sys);
        h_wr  <= 1'b0;
        #1;
    endtask : bw
    task automatic br(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        h_rd <= 1'b1;
        @(posedge clk_sys);
        h_rd <= 1'b0;
        #1 d = rdata;
    endtask : br
    // room for the serial answer to reach the status word
    task automatic sp(input logic [7:0] a, input logic [7:0] v, input logic r);
        bw(hss_pkg::HREG_SP_CMD, {15'h0000, r, a, v});
        cyc(4);
    endtask : sp
    task automatic wstg(input hss_pkg::hss_stage_e s, input int n);
        c = 0;
        while (stage !== s && c < n) begin
            cyc(1);
            c++;
        end
        chk("stage", s, stage);
    endtask : wstg
    task automatic restart(input logic [4:0] ctl);
        bw(hss_pkg::HREG_CTRL, 32'h0000_0000);
        wstg(hss_pkg::STG_STANDBY, 50);
        chk("pll_en", 0, pll_en);
        chk("ports_en", 0, ports_en);
        chk("freq", 0, freq);
        bw(hss_pkg::HREG_CTRL, {27'h000_0000, ctl});
        wstg(hss_pkg::STG_INIT, 3000);
    endtask : restart
    task automatic t_table();
        for (int i = 0; i < 8; i++) begin
            // host pulls the line through init for the secondary entries only, i 4 to 7
            restart({i[1:0], 1'b0, i[2], 1'b1});
            wstg(hss_pkg::STG_CONFIG, 200);
            chk("freq", FTAB[i], freq);
            chk("sec_tbl", i[2], sec_tbl);
            chk("ref_sel", i[1:0], rsel);
        end
    endtask : t_table
    task automatic t_timeout();
        @(posedge clk_sys);
        clk_ok <= 1'b0;
        restart(5'h01);
        wstg(hss_pkg::STG_WAITREF, 200);
        chk("init_cyc", 1, c >= INIT_CYC - 2 && c <= INIT_CYC + 3);
        sp(8'hE8, 8'h00, 1'b1);
        br(hss_pkg::HREG_STATUS);
        chk("answered", 0, d[8]);
        cyc(20);
        chk("stage", hss_pkg::STG_WAITREF, stage);
        @(posedge clk_sys);
        clk_ok <= 1'b1;
        wstg(hss_pkg::STG_CONFIG, 5);
        wstg(hss_pkg::STG_CONNECT, 300);
        chk("cfg_cyc", 1, c >= CFG_CYC - 2 && c <= CFG_CYC + 3);
        // connect bit negated by software with the pin held low
        sp(8'hE7, 8'h02, 1'b0);
        wstg(hss_pkg::STG_COMM, 10);
        chk("ports_en", 1, ports_en);
    endtask : t_timeout
    task automatic t_main();
        restart(5'h01);
        wstg(hss_pkg::STG_CONFIG, 200);
        sp(8'hE7, 8'h01, 1'b0);
        sp(8'hE9, 8'h00, 1'b1);
        br(hss_pkg::HREG_STATUS);
        chk("mask", ROM_MASK_TB, d[7:0]);
        chk("answered", 1, d[8]);
        chk("released", 1, d[10]);
        sp(8'hE9, 8'h01, 1'b0);
        @(posedge clk_sys);
        evt <= 8'h01;
        cyc(4);
        chk("int", 0, link.int_line);
        sp(8'hE8, 8'h01, 1'b0);
        chk("int", 1, link.int_line);
        @(posedge clk_sys);
        evt <= 8'h02;
        cyc(4);
        chk("int", 1, link.int_line);
        @(posedge clk_sys);
        evt <= 8'h01;
        cyc(4);
        chk("int", 0, link.int_line);
        @(posedge clk_sys);
        evt <= 8'h00;
        cyc(100);
        chk("int", 0, link.int_line);
        br(hss_pkg::HREG_STATUS);
        chk("int_low", 1, d[9]);
        chk("stage", hss_pkg::STG_CONFIG, stage);
        sp(8'hEE, 8'h01, 1'b0);
        sp(8'hE7, 8'h00, 1'b0);
        cyc(20);
        chk("stage", hss_pkg::STG_CONNECT, stage);
        bw(hss_pkg::HREG_CTRL, 32'h0000_0005);
        wstg(hss_pkg::STG_COMM, hss_pkg::CONNECT_MAX_CYC);
        chk("ports_en", 1, ports_en);
        sp(8'hE9, 8'h00, 1'b1);
        br(hss_pkg::HREG_STATUS);
        chk("answered", 0, d[8]);
        chk("int", 1, link.int_line);
        @(posedge clk_sys);
        susp <= 1'b1;
        cyc(4);
        chk("int", 0, link.int_line);
        br(4'hC);
        chk("unmapped", 0, d);
    endtask : t_main
    task automatic report_and_stop();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_table();
        t_timeout();
        t_main();
        report_and_stop();
    end
    // ten releases of about 2000 cycles each, with slack
    initial begin
        #(50 * 40_000);
        error_cnt++;
        report_and_stop();
    end
endmodule : hub_stage_sequencer_tb
